// >>> pkg/tcs_pkg.sv
// shared constants, types and decode helpers for the cc attach controller
package tcs_pkg;
  // ==========================================================
  // serial access and timing
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 25;
  localparam int SCLK_DIV = 4;
  localparam int FRAME_BITS = 16;
  localparam int T_CC_DEB_US = 100000;
  localparam int T_CC_DEB_CYC = T_CC_DEB_US * CLK_MHZ;

  // ==========================================================
  // device register map
  localparam logic [6:0] REG_CC_PIN_CONTROL = 7'h10;
  localparam logic [6:0] REG_CMP_CTL = 7'h11;
  localparam logic [6:0] REG_CC_STAT = 7'h12;
  localparam logic [6:0] REG_FILT_TIME = 7'h13;
  localparam logic [6:0] REG_CLR_MASK1 = 7'h14;
  localparam logic [6:0] REG_CLR_MASK2 = 7'h15;
  localparam logic [6:0] REG_CMP_MASK1 = 7'h16;
  localparam logic [6:0] REG_CMP_MASK2 = 7'h17;
  localparam logic [6:0] REG_SAMP_MASK1 = 7'h18;
  localparam logic [6:0] REG_SAMP_MASK2 = 7'h19;
  localparam logic [6:0] REG_HIT1 = 7'h1a;
  localparam logic [6:0] REG_HIT2 = 7'h1b;
  localparam logic [6:0] REG_CHG1 = 7'h1c;
  localparam logic [6:0] REG_CHG2 = 7'h1d;
  localparam logic [6:0] REG_CC_IRQ_MASK = 7'h1e;
  localparam logic [6:0] REG_PWR_IRQ_MASK = 7'h1f;
  localparam logic [6:0] REG_IRQ_EN = 7'h20;
  localparam logic [6:0] REG_VBUS_MASK = 7'h21;
  localparam logic [6:0] REG_VBUS_LEVEL = 7'h22;
  localparam logic [6:0] REG_VBUS_SUPPLY_CONTROL = 7'h23;
  localparam logic [6:0] REG_CLOCK_SOURCE_CONTROL = 7'h24;

  // ==========================================================
  // field values
  localparam logic [7:0] CMP_CTL_OFF = 8'h00;
  localparam logic [7:0] CMP_CTL_BOTH = 8'h07;
  localparam int STAT_FILT_RUN = 0;
  localparam logic [1:0] RP_OFF = 2'h0;
  localparam logic [1:0] RP_DEF = 2'h1;
  localparam logic [1:0] RP_1A5 = 2'h2;
  localparam logic [1:0] RP_3A0 = 2'h3;
  localparam logic [1:0] COMM_NONE = 2'h0;
  localparam logic [1:0] COMM_CC1 = 2'h1;
  localparam logic [1:0] COMM_CC2 = 2'h2;
  localparam logic [7:0] MASK_DEF = 8'h21;
  localparam logic [7:0] MASK_1A5 = 8'h22;
  localparam logic [7:0] MASK_3A0 = 8'h44;
  localparam logic [7:0] VBUS_ZERO_MASK = 8'h01;
  localparam int VBUS_ZERO_BIT = 0;
  localparam logic [7:0] CC_IRQ_ALL = 8'h07;
  localparam logic [7:0] PWR_IRQ_ALL = 8'h01;
  localparam logic [7:0] IRQ_EN_ALL = 8'h07;
  localparam logic [7:0] CLK_KEEP_ALIVE = 8'h01;
  localparam logic [7:0] CHG_CLEAR_ALL = 8'hff;
  localparam logic [7:0] FILT_TIME_DEF = 8'h10;
  localparam logic [3:0] CFG_CLK_IDX = 4'hc;
  localparam logic [3:0] CFG_LAST = 4'hd;

  // ==========================================================
  // types
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } tcs_req_t;

  typedef enum logic [1:0] {
    TERM_OPEN = 2'h0,
    TERM_RD = 2'h1,
    TERM_RA = 2'h2
  } tcs_term_t;

  typedef enum logic [11:0] {
    ST_IDLE = 12'h001,
    ST_STOP = 12'h002,
    ST_POLL = 12'h004,
    ST_CFG = 12'h008,
    ST_WAIT = 12'h010,
    ST_RD = 12'h020,
    ST_CLR = 12'h040,
    ST_DEB = 12'h080,
    ST_CHK = 12'h100,
    ST_VBRD = 12'h200,
    ST_PWR = 12'h400,
    ST_COMM = 12'h800
  } tcs_state_t;

  typedef enum logic [1:0] {
    SP_IDLE = 2'h1,
    SP_BUSY = 2'h2
  } tcs_sp_state_t;

  // ==========================================================
  // threshold helpers, indexed by advertised rp code
  function automatic logic [7:0] mask_of(input logic [1:0] adv);
    case (adv)
      RP_1A5: mask_of = MASK_1A5;
      RP_3A0: mask_of = MASK_3A0;
      default: mask_of = MASK_DEF;
    endcase
  endfunction

  function automatic tcs_term_t classify(input logic [7:0] hit,
                                         input logic [1:0] adv);
    logic open_hit;
    logic rd_hit;
    open_hit = (adv == RP_3A0) ? hit[6] : hit[5];
    rd_hit = (adv == RP_3A0) ? hit[3] : ((adv == RP_1A5) ? hit[1] : hit[0]);
    if (open_hit) classify = TERM_OPEN;
    else if (rd_hit) classify = TERM_RD;
    else classify = TERM_RA;
  endfunction
endpackage

// >>> core/tcs_serial_port.sv
// serial register access engine toward the port controller
`timescale 1ns/1ps
`default_nettype none
module tcs_serial_port #(
  parameter int DIV = tcs_pkg::SCLK_DIV
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // request side
  input wire logic req_valid,
  output logic req_ready,
  input wire tcs_pkg::tcs_req_t req,
  output logic ack,
  output logic [7:0] rdata,
  // device pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  localparam int DW = $clog2(DIV + 1);
  localparam logic [DW-1:0] DIV_M1 = DW'(DIV - 1);
  localparam logic [3:0] LAST_BIT = 4'(tcs_pkg::FRAME_BITS - 1);

  tcs_pkg::tcs_sp_state_t st_ff, nxt_st;
  logic [DW-1:0] div_ff, nxt_div;
  logic [3:0] bit_ff, nxt_bit;
  logic [15:0] shift_ff, nxt_shift;
  logic [7:0] rx_ff, nxt_rx;
  logic sclk_ff, nxt_sclk;
  logic cs_n_ff, nxt_cs_n;
  logic ack_ff, nxt_ack;
  logic miso_meta_ff;
  logic miso_sync_ff;

  // ==========================================================
  // frame sequencing: read flag, address, data, msb first
  always_comb begin
    nxt_st = st_ff;
    nxt_div = div_ff;
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_rx = rx_ff;
    nxt_sclk = sclk_ff;
    nxt_cs_n = cs_n_ff;
    nxt_ack = 1'b0;
    case (st_ff)
      tcs_pkg::SP_IDLE: begin
        if (req_valid) begin
          nxt_st = tcs_pkg::SP_BUSY;
          nxt_shift = {~req.wr, req.addr, req.data};
          nxt_cs_n = 1'b0;
          nxt_bit = 4'h0;
          nxt_div = DIV_M1;
          nxt_sclk = 1'b0;
        end
      end
      tcs_pkg::SP_BUSY: begin
        if (div_ff != '0) begin
          nxt_div = div_ff - 1'b1;
        end else begin
          nxt_div = DIV_M1;
          if (!sclk_ff) begin
            nxt_sclk = 1'b1;
            nxt_rx = {rx_ff[6:0], miso_sync_ff}; // sample on rising edge
          end else begin
            nxt_sclk = 1'b0;
            if (bit_ff == LAST_BIT) begin
              nxt_st = tcs_pkg::SP_IDLE;
              nxt_cs_n = 1'b1;
              nxt_ack = 1'b1;
            end else begin
              nxt_bit = bit_ff + 1'b1;
              nxt_shift = {shift_ff[14:0], 1'b0};
            end
          end
        end
      end
      default: nxt_st = tcs_pkg::SP_IDLE;
    endcase
  end

  // state registers and miso synchroniser
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff <= tcs_pkg::SP_IDLE;
      div_ff <= '0;
      bit_ff <= 4'h0;
      shift_ff <= 16'h0000;
      rx_ff <= 8'h00;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      ack_ff <= 1'b0;
      miso_meta_ff <= 1'b0;
      miso_sync_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      div_ff <= nxt_div;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      rx_ff <= nxt_rx;
      sclk_ff <= nxt_sclk;
      cs_n_ff <= nxt_cs_n;
      ack_ff <= nxt_ack;
      miso_meta_ff <= miso;
      miso_sync_ff <= miso_meta_ff;
    end
  end

  // outputs
  assign req_ready = (st_ff == tcs_pkg::SP_IDLE);
  assign ack = ack_ff;
  assign rdata = rx_ff;
  assign sclk = sclk_ff;
  assign cs_n = cs_n_ff;
  assign mosi = shift_ff[15];
endmodule // tcs_serial_port
`default_nettype wire

// >>> core/tcs_attach_ctrl.sv
// host sequencer for source-side cc attach detection on the port controller
// Notes on behaviour
// - both pins open: watch both for attach, vbus and vconn off.
// - rd on one pin, other open: watch rd pin only, vbus on.
// - ra and open: watch open for sink, ra for cable; power off.
// - ra and rd: watch rd pin only, vconn on.
// - rd/rd debug or ra/ra audio: watch both, vconn off.
// - stop comparator with 00 and poll filter-running idle first.
// - only the keep-alive clock may run while waiting.
// - extra cc debounce after the irq before declaring attach.
// - vbus must read zero-volt before vbus is powered.
// - vconn only toward a pin showing an active cable.
// - comm select points at the pin carrying rd.
`timescale 1ns/1ps
`default_nettype none
module tcs_attach_ctrl #(
  parameter int DEB_CYC = tcs_pkg::T_CC_DEB_CYC,
  parameter logic [7:0] FILT_TIME = tcs_pkg::FILT_TIME_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // user commands
  input wire logic start,
  input wire logic [1:0] adv_sel,
  // user status
  output logic busy,
  output logic attached,
  output logic accessory,
  output logic vbus_on,
  output logic vconn1_on,
  output logic vconn2_on,
  output logic watch_cc1,
  output logic watch_cc2,
  output logic vbus_refused,
  // device pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic irq_n
);
  localparam int CW = $clog2(DEB_CYC + 1);
  localparam logic [CW-1:0] DEB_LOAD = CW'(DEB_CYC);

  tcs_pkg::tcs_state_t state_ff, nxt_state;
  logic [3:0] idx_ff, nxt_idx;
  logic sent_ff, nxt_sent;
  logic [1:0] adv_ff, nxt_adv;
  logic [7:0] hit1_ff, nxt_hit1, hit2_ff, nxt_hit2;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic vzero_ff, nxt_vzero;
  logic vbus_ff, nxt_vbus, vc1_ff, nxt_vc1, vc2_ff, nxt_vc2;
  logic mon1_ff, nxt_mon1, mon2_ff, nxt_mon2;
  logic att_ff, nxt_att, acc_ff, nxt_acc, refused_ff, nxt_refused;
  logic irq_meta_ff, irq_sync_ff;
  logic want, req_valid, req_ready, ack;
  logic [7:0] rdata, cur_hit;
  tcs_pkg::tcs_req_t op;
  tcs_pkg::tcs_term_t t1, t2;
  logic p_vbus, p_vc1, p_vc2, p_mon1, p_mon2, p_acc, vbus_ok;
  logic [1:0] p_comm;

  // ==========================================================
  // configuration writes, one per index, comparator armed last
  function automatic tcs_pkg::tcs_req_t cfg_op(input logic [3:0] i,
                                               input logic [1:0] adv);
    logic [7:0] m;
    m = tcs_pkg::mask_of(adv);
    case (i)
      4'h0: cfg_op = '{1'b1, tcs_pkg::REG_FILT_TIME, FILT_TIME};
      4'h1: cfg_op = '{1'b1, tcs_pkg::REG_CLR_MASK1, m};
      4'h2: cfg_op = '{1'b1, tcs_pkg::REG_CLR_MASK2, m};
      4'h3: cfg_op = '{1'b1, tcs_pkg::REG_CMP_MASK1, m};
      4'h4: cfg_op = '{1'b1, tcs_pkg::REG_CMP_MASK2, m};
      4'h5: cfg_op = '{1'b1, tcs_pkg::REG_SAMP_MASK1, m};
      4'h6: cfg_op = '{1'b1, tcs_pkg::REG_SAMP_MASK2, m};
      4'h7: cfg_op = '{1'b1, tcs_pkg::REG_VBUS_MASK, tcs_pkg::VBUS_ZERO_MASK};
      4'h8: cfg_op = '{1'b1, tcs_pkg::REG_CC_IRQ_MASK, tcs_pkg::CC_IRQ_ALL};
      4'h9: cfg_op = '{1'b1, tcs_pkg::REG_PWR_IRQ_MASK, tcs_pkg::PWR_IRQ_ALL};
      4'ha: cfg_op = '{1'b1, tcs_pkg::REG_IRQ_EN, tcs_pkg::IRQ_EN_ALL};
      4'hb: cfg_op = '{1'b1, tcs_pkg::REG_CC_PIN_CONTROL, {4'h0, adv, adv}};
      4'hc: cfg_op = '{1'b1, tcs_pkg::REG_CLOCK_SOURCE_CONTROL, tcs_pkg::CLK_KEEP_ALIVE};
      default: cfg_op = '{1'b1, tcs_pkg::REG_CMP_CTL, tcs_pkg::CMP_CTL_BOTH};
    endcase
  endfunction

  // ==========================================================
  // connection decision from the two filtered pin states
  always_comb begin
    t1 = tcs_pkg::classify(hit1_ff, adv_ff);
    t2 = tcs_pkg::classify(hit2_ff, adv_ff);
    p_vbus = (t1 == tcs_pkg::TERM_RD) ^ (t2 == tcs_pkg::TERM_RD);
    p_vc1 = (t1 == tcs_pkg::TERM_RA) && (t2 == tcs_pkg::TERM_RD);
    p_vc2 = (t2 == tcs_pkg::TERM_RA) && (t1 == tcs_pkg::TERM_RD);
    p_mon1 = !(t2 == tcs_pkg::TERM_RD && t1 != tcs_pkg::TERM_RD);
    p_mon2 = !(t1 == tcs_pkg::TERM_RD && t2 != tcs_pkg::TERM_RD);
    p_acc = (t1 == t2) && (t1 != tcs_pkg::TERM_OPEN);
    p_comm = !p_vbus ? tcs_pkg::COMM_NONE :
      ((t1 == tcs_pkg::TERM_RD) ? tcs_pkg::COMM_CC1 : tcs_pkg::COMM_CC2);
    vbus_ok = p_vbus && (vbus_ff || vzero_ff);
    cur_hit = idx_ff[0] ? hit2_ff : hit1_ff;
  end

  // ==========================================================
  // main sequencer: one register access per step
  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_adv = adv_ff;
    nxt_hit1 = hit1_ff;
    nxt_hit2 = hit2_ff;
    nxt_cnt = cnt_ff;
    nxt_vzero = vzero_ff;
    nxt_vbus = vbus_ff;
    nxt_vc1 = vc1_ff;
    nxt_vc2 = vc2_ff;
    nxt_mon1 = mon1_ff;
    nxt_mon2 = mon2_ff;
    nxt_att = att_ff;
    nxt_acc = acc_ff;
    nxt_refused = refused_ff;
    want = 1'b0;
    op = '{1'b0, tcs_pkg::REG_CC_STAT, 8'h00};
    case (state_ff)
      tcs_pkg::ST_IDLE: begin
        if (start) begin
          nxt_adv = adv_sel;
          nxt_state = tcs_pkg::ST_STOP;
        end
      end
      tcs_pkg::ST_STOP: begin
        want = 1'b1; // first access also wakes the device
        op = '{1'b1, tcs_pkg::REG_CMP_CTL, tcs_pkg::CMP_CTL_OFF};
        if (ack) nxt_state = tcs_pkg::ST_POLL;
      end
      tcs_pkg::ST_POLL: begin
        want = 1'b1;
        if (ack && !rdata[tcs_pkg::STAT_FILT_RUN]) begin
          nxt_state = tcs_pkg::ST_CFG;
          nxt_idx = 4'h0;
        end
      end
      tcs_pkg::ST_CFG: begin
        want = 1'b1;
        op = cfg_op(idx_ff, adv_ff);
        if (ack) begin
          nxt_idx = idx_ff + 1'b1;
          if (idx_ff == tcs_pkg::CFG_LAST) nxt_state = tcs_pkg::ST_WAIT;
        end
      end
      tcs_pkg::ST_WAIT: begin
        if (!irq_sync_ff) begin
          nxt_state = tcs_pkg::ST_RD;
          nxt_idx = 4'h0;
        end
      end
      tcs_pkg::ST_RD: begin
        want = 1'b1;
        op.addr = idx_ff[0] ? tcs_pkg::REG_HIT2 : tcs_pkg::REG_HIT1;
        if (ack) begin
          if (idx_ff[0]) nxt_hit2 = rdata;
          else nxt_hit1 = rdata;
          nxt_idx = {3'h0, ~idx_ff[0]};
          if (idx_ff[0]) nxt_state = tcs_pkg::ST_CLR;
        end
      end
      tcs_pkg::ST_CLR: begin
        want = 1'b1; // change bits stay set until written back
        op = '{1'b1, idx_ff[0] ? tcs_pkg::REG_CHG2 : tcs_pkg::REG_CHG1,
               tcs_pkg::CHG_CLEAR_ALL};
        if (ack) begin
          nxt_idx = {3'h0, ~idx_ff[0]};
          nxt_vzero = 1'b0;
          if (idx_ff[0]) begin
            nxt_state = tcs_pkg::ST_DEB;
            nxt_cnt = DEB_LOAD;
          end
        end
      end
      tcs_pkg::ST_DEB: begin
        if (cnt_ff != '0) nxt_cnt = cnt_ff - 1'b1;
        else nxt_state = tcs_pkg::ST_CHK;
      end
      tcs_pkg::ST_CHK: begin
        want = 1'b1;
        op.addr = idx_ff[0] ? tcs_pkg::REG_HIT2 : tcs_pkg::REG_HIT1;
        if (ack) begin
          if (rdata != cur_hit) begin // still settling: start over
            if (idx_ff[0]) nxt_hit2 = rdata;
            else nxt_hit1 = rdata;
            nxt_idx = 4'h0;
            nxt_cnt = DEB_LOAD;
            nxt_state = tcs_pkg::ST_DEB;
          end else if (!idx_ff[0]) begin
            nxt_idx = 4'h1;
          end else if (p_vbus && !vbus_ff) begin
            nxt_state = tcs_pkg::ST_VBRD;
          end else begin
            nxt_state = tcs_pkg::ST_PWR;
          end
        end
      end
      tcs_pkg::ST_VBRD: begin
        want = 1'b1;
        op.addr = tcs_pkg::REG_VBUS_LEVEL;
        if (ack) begin
          nxt_vzero = rdata[tcs_pkg::VBUS_ZERO_BIT];
          nxt_state = tcs_pkg::ST_PWR;
        end
      end
      tcs_pkg::ST_PWR: begin
        want = 1'b1;
        op = '{1'b1, tcs_pkg::REG_VBUS_SUPPLY_CONTROL,
               {5'h00, p_vc2, p_vc1, vbus_ok}};
        if (ack) begin
          nxt_vbus = vbus_ok;
          nxt_vc1 = p_vc1;
          nxt_vc2 = p_vc2;
          nxt_mon1 = p_mon1;
          nxt_mon2 = p_mon2;
          nxt_att = p_vbus;
          nxt_acc = p_acc;
          nxt_refused = p_vbus && !vbus_ok;
          nxt_state = tcs_pkg::ST_COMM;
        end
      end
      tcs_pkg::ST_COMM: begin
        want = 1'b1;
        op = '{1'b1, tcs_pkg::REG_CC_PIN_CONTROL,
               {2'h0, p_comm, adv_ff, adv_ff}};
        if (ack) nxt_state = tcs_pkg::ST_WAIT;
      end
      default: nxt_state = tcs_pkg::ST_IDLE;
    endcase
    nxt_sent = ack ? 1'b0 : (sent_ff || (req_valid && req_ready));
  end

  assign req_valid = want && !sent_ff;

  // registers of the sequencer, plus the irq pin synchroniser
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= tcs_pkg::ST_IDLE;
      idx_ff <= 4'h0;
      sent_ff <= 1'b0;
      adv_ff <= tcs_pkg::RP_OFF;
      hit1_ff <= 8'h00;
      hit2_ff <= 8'h00;
      cnt_ff <= '0;
      vzero_ff <= 1'b0;
      vbus_ff <= 1'b0;
      vc1_ff <= 1'b0;
      vc2_ff <= 1'b0;
      mon1_ff <= 1'b1;
      mon2_ff <= 1'b1;
      att_ff <= 1'b0;
      acc_ff <= 1'b0;
      refused_ff <= 1'b0;
      irq_meta_ff <= 1'b1;
      irq_sync_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      sent_ff <= nxt_sent;
      adv_ff <= nxt_adv;
      hit1_ff <= nxt_hit1;
      hit2_ff <= nxt_hit2;
      cnt_ff <= nxt_cnt;
      vzero_ff <= nxt_vzero;
      vbus_ff <= nxt_vbus;
      vc1_ff <= nxt_vc1;
      vc2_ff <= nxt_vc2;
      mon1_ff <= nxt_mon1;
      mon2_ff <= nxt_mon2;
      att_ff <= nxt_att;
      acc_ff <= nxt_acc;
      refused_ff <= nxt_refused;
      irq_meta_ff <= irq_n;
      irq_sync_ff <= irq_meta_ff;
    end
  end

  // serial access engine
  tcs_serial_port u_port (
    .core_clk(core_clk),
    .srst(srst),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req(op),
    .ack(ack),
    .rdata(rdata),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi),
    .miso(spi_miso)
  );

  // outputs
  assign busy = (state_ff != tcs_pkg::ST_IDLE) &&
    (state_ff != tcs_pkg::ST_WAIT);
  assign attached = att_ff;
  assign accessory = acc_ff;
  assign vbus_on = vbus_ff;
  assign vconn1_on = vc1_ff;
  assign vconn2_on = vc2_ff;
  assign watch_cc1 = mon1_ff;
  assign watch_cc2 = mon2_ff;
  assign vbus_refused = refused_ff;

  // ==========================================================
  // checks
  chk_poll_busy: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == tcs_pkg::ST_POLL && ack && rdata[tcs_pkg::STAT_FILT_RUN]
    |=> state_ff == tcs_pkg::ST_POLL)
    else $error("configuration began while the filter was running");
  chk_cfg_entry: assert property (@(posedge core_clk) disable iff (srst)
    $rose(state_ff == tcs_pkg::ST_CFG) |-> $past(state_ff) == tcs_pkg::ST_POLL)
    else $error("configuration entered without polling first");
  chk_deb_hold: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == tcs_pkg::ST_DEB && cnt_ff != '0
    |=> state_ff == tcs_pkg::ST_DEB && cnt_ff == $past(cnt_ff) - 1'b1)
    else $error("debounce wait cut short");
  chk_vbus_safe: assert property (@(posedge core_clk) disable iff (srst)
    $rose(vbus_ff) |-> $past(vzero_ff) && $past(state_ff) == tcs_pkg::ST_PWR)
    else $error("vbus powered without a zero-volt reading");
  chk_vconn_ra: assert property (@(posedge core_clk) disable iff (srst)
    $rose(vc1_ff) |-> $past(t1) == tcs_pkg::TERM_RA && !vc2_ff)
    else $error("vconn driven toward a pin without a cable");
  chk_comm_rd: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == tcs_pkg::ST_COMM && req_valid &&
    op.data[5:4] == tcs_pkg::COMM_CC2
    |-> t2 == tcs_pkg::TERM_RD && vbus_ff == vbus_ok)
    else $error("comm select not on the rd pin");
  chk_open_idle: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == tcs_pkg::ST_PWR && ack && t1 == tcs_pkg::TERM_OPEN &&
    t2 == tcs_pkg::TERM_OPEN
    |=> !vbus_ff && !vc1_ff && !vc2_ff && mon1_ff && mon2_ff)
    else $error("open pins did not leave power off and both watched");
  chk_rd_single: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == tcs_pkg::ST_PWR && ack && t1 == tcs_pkg::TERM_RD &&
    t2 == tcs_pkg::TERM_OPEN
    |=> mon1_ff && !mon2_ff && !vc1_ff && !vc2_ff && att_ff)
    else $error("single rd not handled");
  chk_ra_open: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == tcs_pkg::ST_PWR && ack && t1 == tcs_pkg::TERM_RA &&
    t2 == tcs_pkg::TERM_OPEN
    |=> !vbus_ff && !vc1_ff && mon1_ff && mon2_ff)
    else $error("cable-only state powered a pin");
  chk_ra_rd: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == tcs_pkg::ST_PWR && ack && t1 == tcs_pkg::TERM_RA &&
    t2 == tcs_pkg::TERM_RD
    |=> vc1_ff && !vc2_ff && !mon1_ff && mon2_ff)
    else $error("cable with sink not handled");
  chk_accessory: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == tcs_pkg::ST_PWR && ack && t1 == t2 && t1 != tcs_pkg::TERM_OPEN
    |=> acc_ff && !vc1_ff && !vc2_ff && mon1_ff && mon2_ff)
    else $error("accessory state not handled");
  chk_keep_alive: assert property (@(posedge core_clk) disable iff (srst)
    state_ff == tcs_pkg::ST_CFG && idx_ff == tcs_pkg::CFG_CLK_IDX && req_valid
    |-> op.addr == tcs_pkg::REG_CLOCK_SOURCE_CONTROL && op.data == tcs_pkg::CLK_KEEP_ALIVE)
    else $error("clock control not set to keep-alive only");
endmodule // tcs_attach_ctrl
`default_nettype wire

// >>> dv/tcs_dev_model.sv
// behavioural port controller on the serial register link
`timescale 1ns/1ps
`default_nettype none
module tcs_dev_model (
  // serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic irq_n,
  // attach stimulus
  input wire logic [7:0] hit1,
  input wire logic [7:0] hit2,
  input wire logic vzero,
  input wire logic chg_ev
);
  logic [7:0] regs [0:127];
  logic [15:0] sh;
  logic [7:0] rv;
  logic [4:0] cnt;
  logic rdf;
  logic [1:0] drain;
  logic strap_run;
  logic [3:0] rp_now;
  // ==========================================================
  // frame decode on the rising serial clock
  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
    cnt = 5'h00;
    miso = 1'b0;
    drain = 2'h0;
    strap_run = 1'b1;
  end
  // frame start; the first access also ends power-up strap sampling
  always @(negedge cs_n) begin
    cnt = 5'h00;
    strap_run = 1'b0;
  end
  always @(posedge sclk) begin
    sh = {sh[14:0], mosi};
    cnt = cnt + 5'h01;
    if (cnt == 5'h08) begin
      rdf = sh[7];
      rv = regs[sh[6:0]];
      if (sh[6:0] == 7'h12) begin
        rv = {7'h00, (regs[7'h11] == 8'h07) || (drain != 2'h0)};
        if (drain != 2'h0) drain = drain - 2'h1;
      end
      if (sh[6:0] == 7'h22)
        rv = {7'h00, vzero};
    end
    if (cnt == 5'h10 && !sh[15]) begin
      // a stop leaves the filter winding down for two status reads
      if (sh[14:8] == 7'h11 && sh[7:0] == 8'h00 && regs[7'h11] != 8'h00)
        drain = 2'h2;
      if (sh[14:9] == 6'h0e)
        regs[sh[14:8]] &= ~sh[7:0];
      else
        regs[sh[14:8]] = sh[7:0];
    end
  end
  // read data on falling clock, released line toggles
  always @(negedge sclk or posedge cs_n)
    if (!cs_n && rdf && cnt >= 5'h08 && cnt < 5'h10) miso = rv[5'h0f - cnt];
    else miso = ~miso;
  // filtered level change lands in hit and change bits
  always @(posedge chg_ev) begin
    regs[7'h1c] |= regs[7'h1a] ^ hit1;
    regs[7'h1d] |= regs[7'h1b] ^ hit2;
    regs[7'h1a] = hit1;
    regs[7'h1b] = hit2;
  end
  // strap sampling borrows the rp source, so nothing is advertised
  assign rp_now = strap_run ? 4'h0 : regs[7'h10][3:0];
  // request pin low while enabled change bits are pending
  assign irq_n = !((regs[7'h1c] | regs[7'h1d]) != 8'h00 &&
    regs[7'h20] != 8'h00);
endmodule // tcs_dev_model
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the cc attach controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk, srst, start, chg_ev, vz, sclk, cs_n, mosi, miso, irq_n, busy;
  logic [7:0] st;
  logic [1:0] adv;
  logic [7:0] h1, h2;
  logic [28:0] cs [0:7];
  int errors, checks_done;
  tcs_attach_ctrl #(.DEB_CYC(20)) uut (.core_clk(core_clk), .srst(srst),
    .start(start), .adv_sel(adv), .busy(busy), .attached(st[7]),
    .accessory(st[6]), .vbus_on(st[5]), .vconn1_on(st[4]),
    .vconn2_on(st[3]), .watch_cc1(st[2]), .watch_cc2(st[1]),
    .vbus_refused(st[0]), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso), .irq_n(irq_n));
  tcs_dev_model dev (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .irq_n(irq_n), .hit1(h1), .hit2(h2), .vzero(vz), .chg_ev(chg_ev));
  // ==========================================================
  // clock, watchdog and shared tasks
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #2400000;
    errors++;
    print_verdict();
  end
  task automatic cmp8(input string n, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wait_idle;
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    while ((!seen || busy !== 1'b0) && n < 9000) begin
      @(negedge core_clk);
      seen |= (busy === 1'b1);
      n++;
    end
    if (n >= 9000) errors++;
    @(posedge core_clk);
  endtask
  task automatic ev(input logic [7:0] a, b);
    h1 <= a;
    h2 <= b;
    @(posedge core_clk);
    chg_ev <= 1'b1;
    @(posedge core_clk);
    chg_ev <= 1'b0;
    wait_idle();
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // cases: adv, cc1 hits, cc2 hits, vbus zero, status, comm select
  initial begin
    logic [28:0] c;
    logic [7:0] op;
    logic [7:0] msk;
    {srst, start, chg_ev, vz, adv, h1, h2} = {4'hd, 18'h00000};
    cs[0] = {2'h1, 8'h01, 8'h21, 1'h1, 8'ha4, 2'h1};
    cs[1] = {2'h2, 8'h00, 8'h22, 1'h1, 8'h06, 2'h0};
    cs[2] = {2'h3, 8'h48, 8'h08, 1'h1, 8'ha2, 2'h2};
    cs[3] = {2'h3, 8'h00, 8'h08, 1'h1, 8'hb2, 2'h2};
    cs[4] = {2'h3, 8'h08, 8'h00, 1'h1, 8'hac, 2'h1};
    cs[5] = {2'h3, 8'h08, 8'h08, 1'h1, 8'h46, 2'h0};
    cs[6] = {2'h3, 8'h00, 8'h00, 1'h1, 8'h46, 2'h0};
    cs[7] = {2'h3, 8'h08, 8'h48, 1'h0, 8'h85, 2'h1};
    for (int i = 0; i < 8; i++) begin
      c = cs[i];
      for (int a = 18; a < 37; a++) dev.regs[a] = 8'h00;
      op = (c[28:27] == 2'h3) ? 8'h48 : {6'h08, c[28:27]};
      msk = (c[28:27] == 2'h3) ? tcs_pkg::MASK_3A0 :
        ((c[28:27] == 2'h2) ? tcs_pkg::MASK_1A5 : tcs_pkg::MASK_DEF);
      srst <= 1'b1;
      adv <= c[28:27];
      vz <= c[10];
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      cmp8("reset", st, 8'h06);
      @(posedge core_clk);
      srst <= 1'b0;
      start <= 1'b1;
      wait_idle();
      start <= 1'b0;
      cmp8("mask", dev.regs[7'h16], msk);
      cmp8("rp", {4'h0, dev.rp_now}, {4'h0, c[28:27], c[28:27]});
      cmp8("clk", dev.regs[7'h24], 8'h01);
      cmp8("cmp", dev.regs[7'h11], 8'h07);
      ev(op, op);
      cmp8("open", st, 8'h06);
      ev(c[26:19], c[18:11]);
      cmp8("state", st, c[9:2]);
      cmp8("comm", {6'h00, dev.regs[7'h10][5:4]}, {6'h00, c[1:0]});
      cmp8("chg", dev.regs[7'h1c] | dev.regs[7'h1d], 8'h00);
      $display("case %0d done", i);
    end
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
